// ### hw/lrd_pkg.sv
package lrd_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CONTROL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] LOCK_COUNT_ADDR = 8'h08;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ANALOG_SIGNAL_LOSS_DIS_BIT = 2;
    localparam int CTRL_DIGITAL_SIGNAL_LOSS_DIS_BIT = 3;
    localparam int CTRL_MUTE_BIT = 4;
    localparam int CTRL_EQ_GAIN_BIT = 5;
    localparam int CTRL_DEC_EN_BIT = 6;
    localparam int CTRL_WIDTH = 7;
    localparam logic [6:0] CTRL_RESET = 7'h40;

    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int STAT_LOL_BIT = 0;
    localparam int STAT_DIGITAL_SIGNAL_LOSS_BIT = 1;
    localparam int STAT_ANALOG_SIGNAL_LOSS_BIT = 2;
    localparam int STAT_COMBINED_SIGNAL_LOSS_BIT = 3;

    typedef enum logic [1:0] {
        LRD_MODE_DS3 = 2'h0,
        LRD_MODE_STS1 = 2'h1,
        LRD_MODE_E3 = 2'h2
    } lrd_mode_type;

    // ----------------------------------------
    // Lock supervision: 0.5 % of the window
    // ----------------------------------------
    localparam int LOCK_REF_EDGES = 400;
    localparam int LOCK_TOL_PERMILLE = 5;
    localparam logic [9:0] LOCK_WINDOW = 10'(LOCK_REF_EDGES - 1);
    localparam logic [9:0] LOCK_TOL = 10'(LOCK_REF_EDGES * LOCK_TOL_PERMILLE / 1000);
    localparam logic [9:0] LOCK_LOW = 10'(LOCK_REF_EDGES) - LOCK_TOL;
    localparam logic [9:0] LOCK_HIGH = 10'(LOCK_REF_EDGES) + LOCK_TOL;

    // ----------------------------------------
    // Loss of signal thresholds (symbols)
    // ----------------------------------------
    localparam logic [7:0] DIGITAL_SIGNAL_LOSS_ZERO_RUN = 8'hAF;
    localparam logic [7:0] DIGITAL_SIGNAL_LOSS_WINDOW = 8'hAF;
    localparam logic [7:0] DIGITAL_SIGNAL_LOSS_MIN_ONES = 8'h3A;
    localparam logic [7:0] E3_LOS_ZERO_RUN = 8'h20;
    localparam logic [7:0] E3_LOS_WINDOW = 8'h20;
    localparam logic [7:0] E3_LOS_MIN_ONES = 8'h0B;

    // ----------------------------------------
    // Decoder
    // ----------------------------------------
    localparam int DEC_DEPTH = 4;
    localparam logic [2:0] B3ZS_ZERO_LIMIT = 3'h3;
    localparam logic [2:0] HDB3_ZERO_LIMIT = 3'h4;
endpackage

// ### hw/lrd_sync.sv
`timescale 1ns/1ns
module lrd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Asynchronous inputs
    input wire logic [WIDTH-1:0] async_i,
    // Synchronised level and rising edge
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            stable <= '0;
            last <= '0;
        end else begin
            meta <= async_i;
            stable <= meta;
            last <= stable;
        end
    end

    // Edge taken from the second stage against its copy in the third
    assign level_o = stable;
    assign rise_o = stable & ~last;
endmodule // lrd_sync

// ### hw/lrd_decoder.sv
`timescale 1ns/1ns
module lrd_decoder
    import lrd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Symbols
    input wire logic sym_stb_i,
    input wire logic sym_pos_i,
    input wire logic sym_neg_i,
    input wire logic hdb3_i,
    // Decoded output
    output logic dec_data_o,
    output logic lcv_o
);
    logic [DEC_DEPTH-1:0] pipe;
    logic last_pol;
    logic [2:0] zero_run;

    wire pulse = sym_pos_i ^ sym_neg_i;
    wire both = sym_pos_i & sym_neg_i;
    wire viol = pulse && (sym_pos_i == last_pol);
    // Substitution needs zeros just before V
    wire sub_ok = hdb3_i ? (!pipe[0] && !pipe[1]) : !pipe[0];
    wire [2:0] zero_limit = hdb3_i ? HDB3_ZERO_LIMIT : B3ZS_ZERO_LIMIT;
    wire zero_hit = !pulse && !both && (3'(zero_run + 3'h1) == zero_limit);
    wire [DEC_DEPTH-1:0] shifted = {pipe[DEC_DEPTH-2:0], pulse | both};
    // V restores the zeros it stands in for
    wire [DEC_DEPTH-1:0] cleared = hdb3_i ? 4'h0 : {shifted[3], 3'h0};
    wire [DEC_DEPTH-1:0] next_pipe = (viol && sub_ok) ? cleared : shifted;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pipe <= '0;
            last_pol <= 1'b0;
            zero_run <= 3'h0;
            dec_data_o <= 1'b0;
            lcv_o <= 1'b0;
        end else begin
            lcv_o <= 1'b0;
            if (sym_stb_i) begin
                pipe <= next_pipe;
                dec_data_o <= pipe[DEC_DEPTH-1];
                if (pulse) begin
                    last_pol <= sym_pos_i;
                end
                if (pulse || both) begin
                    zero_run <= 3'h0;
                end else if (zero_run != zero_limit) begin
                    zero_run <= 3'(zero_run + 3'h1);
                end
                lcv_o <= both || (viol && !sub_ok) || zero_hit;
            end
        end
    end
endmodule // lrd_decoder

// ### hw/lrd_receiver.sv
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - With signal present and lock within 0.5%, the recovered clock is output.
// - Absent line or deviation above 0.5% sets loss of lock pin and bit.
// - During loss of lock the reference clock replaces the recovered clock.
// - DS3/STS-1: 175 consecutive zeros declare digital loss and set its bit.
// - Digital loss clears when density over a 175 pulse window exceeds 33%.
// - Analog loss bit follows the amplitude comparator input.
// - Combined loss is digital OR analog, driven on pin and status bit.
// - Both disable bits set suppress loss detection for this channel.
// - E3: a run of 32 zeros (within 10..255) declares loss.
// - E3: loss clears within 10..255 UI after the signal returns.
// - While loss is declared the reference clock drives the clock output.
// - Mute bit set forces both data rails low during loss.
// - When loss clears, recovered data resumes on both rails, or on the positive rail only while the decoder is on.
// - Decoder applies B3ZS in DS3/STS-1 and HDB3 in E3.
// - Violations outside a valid substitution pulse the violation output.
// - Three (B3ZS) or four (HDB3) zeros pulse the violation output.
// - B0V and 00V decode back to three zeros.
// - 000V and B00V decode back to four zeros.
// - Equalizer monitor gain mode suppresses loss detection entirely.
module lrd_receiver
    import lrd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Line side
    input wire logic line_clock_i,
    input wire logic line_in_positive_i,
    input wire logic line_in_negative_i,
    input wire logic reference_clock_in_i,
    input wire logic analog_signal_loss_i,
    // Framer side
    output logic recovered_clock_out_o,
    output logic receive_data_positive_o,
    output logic receive_data_negative_o,
    output logic code_violation_pulse_o,
    output logic loss_of_lock_flag_o,
    output logic combined_loss_flag_o
);
    import lrd_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [4:0] sync_level;
    logic [4:0] sync_rise;

    lrd_sync #(
        .WIDTH(5)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({analog_signal_loss_i, line_in_negative_i, line_in_positive_i,
                  reference_clock_in_i, line_clock_i}),
        .level_o(sync_level),
        .rise_o(sync_rise)
    );

    wire line_clk_level = sync_level[0];
    wire sym_stb = sync_rise[0];
    wire ref_clk_level = sync_level[1];
    wire ref_stb = sync_rise[1];
    wire sym_pos = sync_level[2];
    wire sym_neg = sync_level[3];
    wire analog_signal_loss_raw = sync_level[4];

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [CTRL_WIDTH-1:0] control;
    lrd_mode_type mode;
    assign mode = lrd_mode_type'(control[CTRL_MODE_LSB +: 2]);
    wire is_e3 = (mode == LRD_MODE_E3);
    wire analog_signal_loss_dis = control[CTRL_ANALOG_SIGNAL_LOSS_DIS_BIT];
    wire digital_signal_loss_dis = control[CTRL_DIGITAL_SIGNAL_LOSS_DIS_BIT];
    wire mute_en = control[CTRL_MUTE_BIT];
    wire eq_monitor = control[CTRL_EQ_GAIN_BIT];
    wire dec_en = control[CTRL_DEC_EN_BIT];
    // Both disables together, or monitor gain mode, switch detection off
    wire los_suppress = (analog_signal_loss_dis && digital_signal_loss_dis) || eq_monitor;

    // ----------------------------------------
    // Lock supervision
    // ----------------------------------------
    logic [9:0] ref_count;
    logic [9:0] line_count;
    logic [9:0] lock_count;
    logic lol;

    wire window_end = ref_stb && (ref_count == LOCK_WINDOW);
    wire out_of_range = (line_count < LOCK_LOW) || (line_count > LOCK_HIGH);
    wire [9:0] next_line_count = (line_count == 10'h3FF) ? line_count : 10'(line_count + 10'h1);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_count <= 10'h0;
            line_count <= 10'h0;
            lock_count <= 10'h0;
            lol <= 1'b0;
        end else begin
            if (window_end) begin
                ref_count <= 10'h0;
                line_count <= {9'h0, sym_stb};
                lock_count <= line_count;
                // No line edges at all falls out of range too
                lol <= out_of_range;
            end else begin
                if (ref_stb) begin
                    ref_count <= 10'(ref_count + 10'h1);
                end
                if (sym_stb) begin
                    line_count <= next_line_count;
                end
            end
        end
    end

    // ----------------------------------------
    // Digital / E3 loss of signal
    // ----------------------------------------
    logic digital_signal_loss;
    logic [7:0] zero_run;
    logic [7:0] win_count;
    logic [7:0] ones_count;

    wire sym_one = sym_pos | sym_neg;
    wire [7:0] run_limit = is_e3 ? E3_LOS_ZERO_RUN : DIGITAL_SIGNAL_LOSS_ZERO_RUN;
    wire [7:0] win_limit = is_e3 ? E3_LOS_WINDOW : DIGITAL_SIGNAL_LOSS_WINDOW;
    wire [7:0] min_ones = is_e3 ? E3_LOS_MIN_ONES : DIGITAL_SIGNAL_LOSS_MIN_ONES;
    wire [7:0] next_ones = sym_one ? 8'(ones_count + 8'h1) : ones_count;
    wire win_done = (8'(win_count + 8'h1) == win_limit);
    wire run_done = !sym_one && (8'(zero_run + 8'h1) >= run_limit);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            digital_signal_loss <= 1'b0;
            zero_run <= 8'h0;
            win_count <= 8'h0;
            ones_count <= 8'h0;
        end else if (los_suppress) begin
            digital_signal_loss <= 1'b0;
            zero_run <= 8'h0;
            win_count <= 8'h0;
            ones_count <= 8'h0;
        end else if (sym_stb) begin
            zero_run <= sym_one ? 8'h0 : (run_done ? zero_run : 8'(zero_run + 8'h1));
            if (!digital_signal_loss) begin
                win_count <= 8'h0;
                ones_count <= 8'h0;
                if (run_done) begin
                    digital_signal_loss <= 1'b1;
                end
            end else if (win_done) begin
                win_count <= 8'h0;
                ones_count <= 8'h0;
                // Density above 33% over the window
                if (next_ones >= min_ones) begin
                    digital_signal_loss <= 1'b0;
                end
            end else begin
                win_count <= 8'(win_count + 8'h1);
                ones_count <= next_ones;
            end
        end
    end

    wire analog_signal_loss = analog_signal_loss_raw && !los_suppress;
    wire combined_signal_loss = digital_signal_loss || analog_signal_loss;
    wire use_reference = lol || combined_signal_loss;

    // ----------------------------------------
    // Decoder
    // ----------------------------------------
    logic dec_data;
    logic dec_lcv;

    lrd_decoder u_decoder (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .sym_stb_i(sym_stb),
        .sym_pos_i(sym_pos),
        .sym_neg_i(sym_neg),
        .hdb3_i(is_e3),
        .dec_data_o(dec_data),
        .lcv_o(dec_lcv)
    );

    wire mute = mute_en && combined_signal_loss;
    wire next_pos = mute ? 1'b0 : (dec_en ? dec_data : sym_pos);
    wire next_neg = (mute || dec_en) ? 1'b0 : sym_neg;

    // ----------------------------------------
    // Framer side outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            recovered_clock_out_o <= 1'b0;
            receive_data_positive_o <= 1'b0;
            receive_data_negative_o <= 1'b0;
            code_violation_pulse_o <= 1'b0;
            loss_of_lock_flag_o <= 1'b0;
            combined_loss_flag_o <= 1'b0;
        end else begin
            // Switch-over may shorten one clock phase
            recovered_clock_out_o <= use_reference ? ref_clk_level : line_clk_level;
            if (sym_stb) begin
                receive_data_positive_o <= next_pos;
                receive_data_negative_o <= next_neg;
            end else begin
                // Decoder switch-on must not leave a stale negative rail
                if (mute) begin
                    receive_data_positive_o <= 1'b0;
                end
                if (mute || dec_en) begin
                    receive_data_negative_o <= 1'b0;
                end
            end
            code_violation_pulse_o <= dec_en && dec_lcv;
            loss_of_lock_flag_o <= lol;
            combined_loss_flag_o <= combined_signal_loss;
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire sel_ctrl = (wb_adr_i == CONTROL_ADDR);
    wire sel_stat = (wb_adr_i == STATUS_ADDR);
    wire sel_lock = (wb_adr_i == LOCK_COUNT_ADDR);
    wire ctrl_write = wb_req && wb_we_i && sel_ctrl && wb_sel_i[0];
    wire [31:0] status_word = {28'h0, combined_signal_loss, analog_signal_loss, digital_signal_loss, lol};
    wire [31:0] read_word = sel_ctrl ? {25'h0, control} :
                            sel_stat ? status_word :
                            sel_lock ? {22'h0, lock_count} : 32'h0;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control <= CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? read_word : 32'h0;
            if (ctrl_write) begin
                control <= wb_dat_i[CTRL_WIDTH-1:0];
            end
        end
    end
endmodule // lrd_receiver

// ### verification/lrd_framer_model.sv
`timescale 1ns/1ns
module lrd_framer_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Receive side of the block
    input wire logic rx_clk_i,
    input wire logic lcv_i,
    // Counters
    output int clk_count_o,
    output int lcv_count_o
);
    logic last_clk;

    // Edges found by sampling, as the clock is slower than ours
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_clk <= 1'b0;
            clk_count_o <= 0;
            lcv_count_o <= 0;
        end else begin
            last_clk <= rx_clk_i;
            if (rx_clk_i && !last_clk) clk_count_o <= clk_count_o + 1;
            if (lcv_i) lcv_count_o <= lcv_count_o + 1;
        end
    end
endmodule // lrd_framer_model

// ### verification/lrd_receiver_props.sv
`timescale 1ns/1ns
module lrd_receiver_props
    import lrd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Framer side
    input wire logic receive_data_positive_o,
    input wire logic receive_data_negative_o,
    input wire logic code_violation_pulse_o,
    input wire logic loss_of_lock_flag_o,
    input wire logic combined_loss_flag_o
);
    // ----
    // Control copy, one cycle behind the block
    // ----
    logic [6:0] ctrl;
    logic sup;
    assign sup = (ctrl[3] & ctrl[2]) | ctrl[5];
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) ctrl <= CTRL_RESET;
        else if (wb_ack_o && wb_we_i && wb_adr_i == CONTROL_ADDR && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[6:0];
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ctrl_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CONTROL_ADDR
        |-> wb_dat_o == {25'h0, ctrl}) else $error("control read differs");
    a_reset_clear: assert property (
        !$past(reset_n_i) |-> !loss_of_lock_flag_o && !combined_loss_flag_o)
        else $error("flags set after reset");
    a_lcv_one_pulse: assert property (code_violation_pulse_o |=> !code_violation_pulse_o)
        else $error("violation pulse too long");
    a_lcv_decoder_off: assert property (
        !ctrl[6] && !$past(ctrl[6], 3) |-> !code_violation_pulse_o)
        else $error("violation pulse with decoder off");
    a_neg_decoded: assert property (
        ctrl[6] && $past(ctrl[6], 2) |-> !receive_data_negative_o)
        else $error("negative rail active while decoding");
    a_mute_rails: assert property (
        ctrl[4] && $past(ctrl[4], 2) && combined_loss_flag_o && $past(combined_loss_flag_o)
        |-> !receive_data_positive_o && !receive_data_negative_o)
        else $error("rails not muted in loss");
    a_loss_suppressed: assert property (sup && $past(sup, 2) |-> !combined_loss_flag_o)
        else $error("loss flag while suppressed");

    c_violation: cover property (code_violation_pulse_o);
    c_loss: cover property ($rose(combined_loss_flag_o));
    c_lock_lost: cover property ($rose(loss_of_lock_flag_o));
endmodule // lrd_receiver_props

bind lrd_receiver lrd_receiver_props i_lrd_receiver_props (.ref_clk_i, .reset_n_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .receive_data_positive_o, .receive_data_negative_o, .code_violation_pulse_o,
    .loss_of_lock_flag_o, .combined_loss_flag_o);

// ### verification/tb_line_receive_lock_los_decoder.sv
`timescale 1ns/1ns
module tb_line_receive_lock_los_decoder;
    import lrd_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic line_clock_i = 1'b0;
    logic line_in_positive_i = 1'b0;
    logic line_in_negative_i = 1'b0;
    logic reference_clock_in_i = 1'b0;
    logic analog_signal_loss_i = 1'b0;
    logic recovered_clock_out_o, receive_data_positive_o, receive_data_negative_o;
    logic code_violation_pulse_o, loss_of_lock_flag_o, combined_loss_flag_o;
    logic line_on = 1'b0;
    logic last_pos = 1'b0;
    logic seen_pos = 1'b0;
    logic [31:0] q;
    int n_errors = 0;
    int cmp_count = 0;
    int clk_count, lcv_count, n;

    lrd_receiver i_lrd_receiver (.ref_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_clock_i,
        .line_in_positive_i, .line_in_negative_i, .reference_clock_in_i, .analog_signal_loss_i,
        .recovered_clock_out_o, .receive_data_positive_o, .receive_data_negative_o,
        .code_violation_pulse_o, .loss_of_lock_flag_o, .combined_loss_flag_o);
    lrd_framer_model i_lrd_framer_model (.ref_clk_i, .reset_n_i,
        .rx_clk_i(recovered_clock_out_o), .lcv_i(code_violation_pulse_o),
        .clk_count_o(clk_count), .lcv_count_o(lcv_count));

    // ----
    // Clocks: line and reference share 125 ns, line one stops when cut
    // ----
    always #5 ref_clk_i = ~ref_clk_i;
    always begin
        #62 line_clock_i <= line_on & ~line_clock_i;
        #63 line_clock_i <= line_on & ~line_clock_i;
    end
    always begin
        #63 reference_clock_in_i <= ~reference_clock_in_i;
        #62 reference_clock_in_i <= ~reference_clock_in_i;
    end
    always @(posedge ref_clk_i) if (receive_data_positive_o === 1'b1) seen_pos <= 1'b1;

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t no bus acknowledge", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [31:0] d);
        xfer(CONTROL_ADDR, 1'b1, d);
        repeat (20) @(posedge ref_clk_i);
    endtask
    // Rails move after the line clock falls, clear of its sampling edge
    task automatic sym(input logic p, input logic m);
        @(negedge line_clock_i);
        @(posedge ref_clk_i);
        line_in_positive_i <= p;
        line_in_negative_i <= m;
    endtask
    task automatic marks(input int k);
        repeat (k) begin
            last_pos = ~last_pos;
            sym(last_pos, ~last_pos);
        end
    endtask
    task automatic zeros(input int k);
        repeat (k) sym(1'b0, 1'b0);
    endtask
    task automatic subst(input int nz, input logic b);
        if (b) begin
            last_pos = ~last_pos;
            sym(last_pos, ~last_pos);
        end
        zeros(nz);
        sym(last_pos, ~last_pos);
    endtask
    task automatic flag(input logic e);
        // Past the flag update, before the next line clock fall
        repeat (11) @(posedge ref_clk_i);
        chk(32'(combined_loss_flag_o), 32'(e));
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        xfer(CONTROL_ADDR, 1'b0, 32'h0);
        chk(q, {25'h0, CTRL_RESET});
        xfer(STATUS_ADDR, 1'b0, 32'h0);
        chk(q, 32'h0);
        xfer(8'h0C, 1'b1, 32'hFF);
        xfer(8'h0C, 1'b0, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_lock;
        line_on <= 1'b1;
        repeat (11000) @(posedge ref_clk_i);
        chk(32'(loss_of_lock_flag_o), 32'h0);
        line_on <= 1'b0;
        repeat (11000) @(posedge ref_clk_i);
        chk(32'(loss_of_lock_flag_o), 32'h1);
        xfer(STATUS_ADDR, 1'b0, 32'h0);
        chk(q & 32'h1, 32'h1);
        n = clk_count;
        repeat (100) @(posedge ref_clk_i);
        chk(32'(clk_count - n > 6), 32'h1);
        line_on <= 1'b1;
        repeat (11000) @(posedge ref_clk_i);
        chk(32'(loss_of_lock_flag_o), 32'h0);
        $display("test lock done");
    endtask
    task automatic t_digital_signal_loss;
        marks(180);
        flag(1'b0);
        n = lcv_count;
        zeros(170);
        flag(1'b0);
        zeros(10);
        flag(1'b1);
        xfer(STATUS_ADDR, 1'b0, 32'h0);
        chk(q & 32'hA, 32'hA);
        chk(32'(lcv_count > n), 32'h1);
        marks(180);
        flag(1'b0);
        n = lcv_count;
        marks(20);
        subst(1, 1'b1);
        marks(6);
        subst(2, 1'b0);
        marks(6);
        chk(32'(lcv_count - n), 32'h0);
        sym(last_pos, ~last_pos);
        marks(6);
        chk(32'(lcv_count - n), 32'h1);
        $display("test digital loss done");
    endtask
    task automatic t_analog_signal_loss;
        analog_signal_loss_i <= 1'b1;
        flag(1'b1);
        xfer(STATUS_ADDR, 1'b0, 32'h0);
        chk(q & 32'hC, 32'hC);
        wr(32'h44);
        flag(1'b1);
        wr(32'h4C);
        flag(1'b0);
        xfer(STATUS_ADDR, 1'b0, 32'h0);
        chk(q & 32'hE, 32'h0);
        wr(32'h60);
        flag(1'b0);
        wr(32'h10);
        seen_pos = 1'b0;
        marks(10);
        chk(32'(seen_pos), 32'h0);
        analog_signal_loss_i <= 1'b0;
        marks(4);
        seen_pos = 1'b0;
        marks(10);
        chk(32'(seen_pos), 32'h1);
        $display("test analog loss done");
    endtask
    task automatic t_e3;
        wr(32'h42);
        marks(40);
        zeros(27);
        flag(1'b0);
        zeros(6);
        flag(1'b1);
        marks(33);
        flag(1'b0);
        marks(8);
        n = lcv_count;
        subst(3, 1'b0);
        marks(6);
        subst(2, 1'b1);
        marks(6);
        chk(32'(lcv_count - n), 32'h0);
        zeros(5);
        marks(6);
        chk(32'(lcv_count > n), 32'h1);
        $display("test e3 done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #900000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        t_reset();
        t_lock();
        t_digital_signal_loss();
        t_analog_signal_loss();
        t_e3();
        print_verdict();
    end
endmodule // tb_line_receive_lock_los_decoder
